//--- hdl/eeprom_loader_pkg.sv
// Constants, register layout and state encoding for the serial EEPROM loader.
// Assumes a single core clock and a two-wire EEPROM that acknowledges each byte.
//
// Contract
// - Start bit rising launches cycle; command picks direction
// - Hardware clears start bit when cycle ends
// - Error flag set on missing acknowledge
// - Complete flag set only after successful autoload
// - Rate field divides clock 4096/2048/1024/128
// - Autoload control bit one blocks autoload
// - Fast bit makes autoload eight times faster
// - In-progress flag high while autoload runs
// - Word address field selects software cycle location
// - Data field holds word to write
package eeprom_loader_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'h70;
   localparam logic [7:0] STATUS_OFFSET = 8'hA0;
   localparam logic [7:0] MASK_OFFSET = 8'hA4;

   // Control/status word, bit 31 first
   typedef struct packed {
      logic [15:0] data;
      logic [6:0] wordAddr;
      logic inProg;
      logic fast;
      logic autoDis;
      logic [1:0] rate;
      logic done;
      logic err;
      logic cmd;
      logic start;
   } ctrl_t;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0080;

   // Interrupt status bits
   localparam int STAT_WIDTH = 3;
   localparam int STAT_OP_DONE = 0;
   localparam int STAT_ERR = 1;
   localparam int STAT_AUTO_DONE = 2;
   localparam logic [STAT_WIDTH-1:0] STAT_RESET = 3'h0;

   // ----------------------------------------------------------------
   // Serial clock: cycles per quarter of a serial clock period
   // ----------------------------------------------------------------
   localparam logic [10:0] QTR_RATE0 = 11'h400;   // divide by 4096
   localparam logic [10:0] QTR_RATE1 = 11'h200;   // divide by 2048
   localparam logic [10:0] QTR_RATE2 = 11'h100;   // divide by 1024
   localparam logic [10:0] QTR_RATE3 = 11'h020;   // divide by 128
   localparam int FAST_SHIFT = 3;                  // eight times faster

   // ----------------------------------------------------------------
   // EEPROM framing
   // ----------------------------------------------------------------
   localparam logic [7:0] DEV_WRITE = 8'hA0;
   localparam logic [7:0] DEV_READ = 8'hA1;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [2:0] BYTE_ADDR = 3'h1;
   localparam logic [2:0] BYTE_HI = 3'h3;
   localparam logic [2:0] BYTE_LO = 3'h4;
   localparam logic [6:0] AUTOLOAD_LAST = 7'h07;  // eight words loaded
   localparam logic [4:0] AUTOLOAD_HOLD = 5'h10;  // cycles before autoload

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_BYTE = 3'h3,
      ST_STOP = 3'h2,
      ST_FINISH = 3'h6
   } state_t;

endpackage

//--- hdl/eeprom_clk_div.sv
// Quarter-period tick generator for the EEPROM serial clock.
// Assumes rate and fast settings stay put while a cycle is running.
`timescale 1ns/1ps
module eeprom_clk_div (
   input wire logic clk,          // Core clock
   input wire logic reset,        // Asynchronous reset, active high
   input wire logic [1:0] rate,   // Serial clock rate select
   input wire logic fast,         // Divide quarter by eight
   output logic tick              // One pulse per quarter period
);

   logic [9:0] cnt_r;
   logic [9:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;
   logic [10:0] quarter;
   logic [9:0] limit;

   // ----------------------------------------------------------------
   // Count to the selected quarter length
   // ----------------------------------------------------------------
   // Compare with >= so a shortened limit never strands the counter
   always_comb
   begin
      case (rate)
         2'h0: quarter = eeprom_loader_pkg::QTR_RATE0;
         2'h1: quarter = eeprom_loader_pkg::QTR_RATE1;
         2'h2: quarter = eeprom_loader_pkg::QTR_RATE2;
         default: quarter = eeprom_loader_pkg::QTR_RATE3;
      endcase
      if (fast)
      begin
         quarter = quarter >> eeprom_loader_pkg::FAST_SHIFT;
      end
      limit = 10'(quarter - 11'h001);
      tick_nxt = (cnt_r >= limit);
      cnt_nxt = tick_nxt ? 10'h000 : 10'(cnt_r + 10'h001);
   end

   // Registers
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_r <= 10'h000;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;

endmodule

//--- hdl/eeprom_autoload_access.sv
// Serial EEPROM controller: autoload after reset and single word cycles.
// Assumes an open-drain data line resolved outside and a pulled-up bus.
`timescale 1ns/1ps
module eeprom_autoload_access (
   input wire logic clk,               // Core clock, 20 MHz
   input wire logic reset,             // Asynchronous reset, active high
   input wire logic [7:0] regAddr,     // Register byte address
   input wire logic [31:0] regWrData,  // Register write data
   input wire logic regWr,             // Write strobe
   input wire logic regRd,             // Read strobe
   output logic [31:0] regRdData,      // Read data, cycle after strobe
   output logic sclOut,                // EEPROM serial clock
   input wire logic sdaIn,             // EEPROM data line level
   output logic sdaOut,                // Data line drive value, always low
   output logic sdaOe,                 // High while pulling data line low
   output logic [15:0] cfgWord,        // Autoloaded word
   output logic [6:0] cfgAddr,         // Word address of cfgWord
   output logic cfgValid,              // Pulse with each autoloaded word
   output logic irq                    // Level interrupt
);

   eeprom_loader_pkg::state_t state_r, state_nxt;
   eeprom_loader_pkg::ctrl_t ctrl_r, ctrl_nxt, wrCtrl;
   logic [1:0] q_r, q_nxt;
   logic [3:0] bitCnt_r, bitCnt_nxt;
   logic [2:0] byteIdx_r, byteIdx_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [15:0] rx_r, rx_nxt;
   logic ackErr_r, ackErr_nxt;
   logic isAuto_r, isAuto_nxt;
   logic autoPend_r, autoPend_nxt;
   logic [4:0] hold_r, hold_nxt;
   logic [6:0] loadIdx_r, loadIdx_nxt;
   logic scl_r, scl_nxt;
   logic sdaOe_r, sdaOe_nxt;
   logic [15:0] cfgWord_r, cfgWord_nxt;
   logic [6:0] cfgAddr_r, cfgAddr_nxt;
   logic cfgValid_r, cfgValid_nxt;
   logic [eeprom_loader_pkg::STAT_WIDTH-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev, w1c;
   logic irq_r, irq_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic tick;
   logic opWrite;
   logic [6:0] opAddr;
   logic holdDone;

   // ----------------------------------------------------------------
   // Serial clock timebase
   // ----------------------------------------------------------------
   eeprom_clk_div u_div (
      .clk(clk),
      .reset(reset),
      .rate(ctrl_r.rate),
      .fast(ctrl_r.fast),
      .tick(tick)
   );

   // Byte sent at each position of a frame
   function automatic logic [7:0] tx_byte(input logic [2:0] idx, input logic wr,
                                          input logic [6:0] addr, input logic [15:0] data);
      case (idx)
         3'h0: tx_byte = eeprom_loader_pkg::DEV_WRITE;
         3'h1: tx_byte = {1'b0, addr};
         3'h2: tx_byte = wr ? data[15:8] : eeprom_loader_pkg::DEV_READ;
         3'h3: tx_byte = wr ? data[7:0] : eeprom_loader_pkg::IDLE_BYTE;
         default: tx_byte = eeprom_loader_pkg::IDLE_BYTE;
      endcase
   endfunction

   assign opWrite = !isAuto_r && ctrl_r.cmd;
   assign opAddr = isAuto_r ? loadIdx_r : ctrl_r.wordAddr;
   assign holdDone = (hold_r == eeprom_loader_pkg::AUTOLOAD_HOLD);

   // ----------------------------------------------------------------
   // Engine and control register
   // ----------------------------------------------------------------
   // Fields are frozen while busy so a frame never sees a torn address
   always_comb
   begin
      state_nxt = state_r;
      ctrl_nxt = ctrl_r;
      q_nxt = q_r;
      bitCnt_nxt = bitCnt_r;
      byteIdx_nxt = byteIdx_r;
      shift_nxt = shift_r;
      rx_nxt = rx_r;
      ackErr_nxt = ackErr_r;
      isAuto_nxt = isAuto_r;
      autoPend_nxt = autoPend_r;
      loadIdx_nxt = loadIdx_r;
      scl_nxt = scl_r;
      sdaOe_nxt = sdaOe_r;
      cfgWord_nxt = cfgWord_r;
      cfgAddr_nxt = cfgAddr_r;
      cfgValid_nxt = 1'b0;
      ev = '0;
      hold_nxt = holdDone ? hold_r : 5'(hold_r + 5'h01);
      wrCtrl = eeprom_loader_pkg::ctrl_t'(regWrData);
      if (regWr && regAddr == eeprom_loader_pkg::CTRL_OFFSET && state_r == eeprom_loader_pkg::ST_IDLE)
      begin
         ctrl_nxt.data = wrCtrl.data;
         ctrl_nxt.wordAddr = wrCtrl.wordAddr;
         ctrl_nxt.fast = wrCtrl.fast;
         ctrl_nxt.autoDis = wrCtrl.autoDis;
         ctrl_nxt.rate = wrCtrl.rate;
         ctrl_nxt.cmd = wrCtrl.cmd;
         if (wrCtrl.start && !ctrl_r.start)
         begin
            ctrl_nxt.start = 1'b1;
         end
      end
      case (state_r)
         eeprom_loader_pkg::ST_IDLE:
         begin
            scl_nxt = 1'b1;
            sdaOe_nxt = 1'b0;
            if (autoPend_r && holdDone && ctrl_r.autoDis)
            begin
               autoPend_nxt = 1'b0;
            end
            else if ((autoPend_r && holdDone) || (!autoPend_r && ctrl_r.start))
            begin
               isAuto_nxt = autoPend_r;
               ctrl_nxt.inProg = autoPend_r;
               autoPend_nxt = 1'b0;
               loadIdx_nxt = 7'h00;
               state_nxt = eeprom_loader_pkg::ST_START;
               q_nxt = 2'h0;
               byteIdx_nxt = 3'h0;
               ackErr_nxt = 1'b0;
            end
         end
         eeprom_loader_pkg::ST_START:
         begin
            if (tick)
            begin
               q_nxt = 2'(q_r + 2'h1);
               case (q_r)
                  2'h0: sdaOe_nxt = 1'b0;
                  2'h1: scl_nxt = 1'b1;
                  2'h2: sdaOe_nxt = 1'b1;       // Data falls while clock high
                  default:
                  begin
                     scl_nxt = 1'b0;
                     shift_nxt = tx_byte(byteIdx_r, opWrite, opAddr, ctrl_r.data);
                     bitCnt_nxt = 4'h0;
                     state_nxt = eeprom_loader_pkg::ST_BYTE;
                  end
               endcase
            end
         end
         eeprom_loader_pkg::ST_BYTE:
         begin
            if (tick)
            begin
               q_nxt = 2'(q_r + 2'h1);
               case (q_r)
                  2'h0:
                  begin
                     if (bitCnt_r != eeprom_loader_pkg::BIT_ACK)
                     begin
                        sdaOe_nxt = !shift_r[7];
                     end
                     else
                     begin
                        // Master acknowledges the high byte, not the last
                        sdaOe_nxt = !opWrite && byteIdx_r == eeprom_loader_pkg::BYTE_HI;
                     end
                  end
                  2'h1: scl_nxt = 1'b1;
                  2'h2:
                  begin
                     if (bitCnt_r != eeprom_loader_pkg::BIT_ACK)
                     begin
                        if (!opWrite && byteIdx_r >= eeprom_loader_pkg::BYTE_HI)
                        begin
                           rx_nxt = {rx_r[14:0], sdaIn};
                        end
                     end
                     else if ((opWrite || byteIdx_r < eeprom_loader_pkg::BYTE_HI) && sdaIn)
                     begin
                        ackErr_nxt = 1'b1;
                     end
                  end
                  default:
                  begin
                     scl_nxt = 1'b0;
                     if (bitCnt_r != eeprom_loader_pkg::BIT_ACK)
                     begin
                        shift_nxt = {shift_r[6:0], 1'b1};
                        bitCnt_nxt = 4'(bitCnt_r + 4'h1);
                     end
                     else if (ackErr_r)
                     begin
                        state_nxt = eeprom_loader_pkg::ST_STOP;   // Abort frame
                     end
                     else if ((opWrite && byteIdx_r == eeprom_loader_pkg::BYTE_HI) ||
                              (!opWrite && byteIdx_r == eeprom_loader_pkg::BYTE_LO))
                     begin
                        state_nxt = eeprom_loader_pkg::ST_STOP;
                     end
                     else if (!opWrite && byteIdx_r == eeprom_loader_pkg::BYTE_ADDR)
                     begin
                        byteIdx_nxt = 3'h2;     // Repeated start for the read
                        state_nxt = eeprom_loader_pkg::ST_START;
                     end
                     else
                     begin
                        byteIdx_nxt = 3'(byteIdx_r + 3'h1);
                        shift_nxt = tx_byte(byteIdx_nxt, opWrite, opAddr, ctrl_r.data);
                        bitCnt_nxt = 4'h0;
                     end
                  end
               endcase
            end
         end
         eeprom_loader_pkg::ST_STOP:
         begin
            if (tick)
            begin
               q_nxt = 2'(q_r + 2'h1);
               case (q_r)
                  2'h0: sdaOe_nxt = 1'b1;
                  2'h1: scl_nxt = 1'b1;
                  2'h2: sdaOe_nxt = 1'b0;      // Data rises while clock high
                  default: state_nxt = eeprom_loader_pkg::ST_FINISH;
               endcase
            end
         end
         eeprom_loader_pkg::ST_FINISH:
         begin
            ctrl_nxt.err = ackErr_r;
            state_nxt = eeprom_loader_pkg::ST_IDLE;
            if (isAuto_r)
            begin
               cfgWord_nxt = rx_r;
               cfgAddr_nxt = loadIdx_r;
               cfgValid_nxt = !ackErr_r;
               ev[eeprom_loader_pkg::STAT_ERR] = ackErr_r;
               if (ackErr_r || loadIdx_r == eeprom_loader_pkg::AUTOLOAD_LAST)
               begin
                  ctrl_nxt.inProg = 1'b0;
                  ctrl_nxt.done = !ackErr_r;
                  ev[eeprom_loader_pkg::STAT_AUTO_DONE] = !ackErr_r;
               end
               else
               begin
                  loadIdx_nxt = 7'(loadIdx_r + 7'h01);
                  byteIdx_nxt = 3'h0;
                  q_nxt = 2'h0;
                  state_nxt = eeprom_loader_pkg::ST_START;
               end
            end
            else
            begin
               ctrl_nxt.start = 1'b0;
               if (!ackErr_r && !ctrl_r.cmd)
               begin
                  ctrl_nxt.data = rx_r;
               end
               ev[eeprom_loader_pkg::STAT_OP_DONE] = 1'b1;
               ev[eeprom_loader_pkg::STAT_ERR] = ackErr_r;
            end
         end
         default: state_nxt = eeprom_loader_pkg::ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Interrupts and read port
   // ----------------------------------------------------------------
   // An event in the clearing cycle survives: set is applied after clear
   always_comb
   begin
      w1c = '0;
      mask_nxt = mask_r;
      if (regWr && regAddr == eeprom_loader_pkg::STATUS_OFFSET)
      begin
         w1c = regWrData[eeprom_loader_pkg::STAT_WIDTH-1:0];
      end
      if (regWr && regAddr == eeprom_loader_pkg::MASK_OFFSET)
      begin
         mask_nxt = regWrData[eeprom_loader_pkg::STAT_WIDTH-1:0];
      end
      stat_nxt = (stat_r & ~w1c) | ev;
      irq_nxt = |(stat_nxt & mask_nxt);
      rd_nxt = 32'h0000_0000;
      if (regRd)
      begin
         case (regAddr)
            eeprom_loader_pkg::CTRL_OFFSET: rd_nxt = ctrl_r;
            eeprom_loader_pkg::STATUS_OFFSET: rd_nxt = {29'h0, stat_r};
            eeprom_loader_pkg::MASK_OFFSET: rd_nxt = {29'h0, mask_r};
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Registers
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_r <= eeprom_loader_pkg::ST_IDLE;
         ctrl_r <= eeprom_loader_pkg::CTRL_RESET;
         q_r <= 2'h0;
         bitCnt_r <= 4'h0;
         byteIdx_r <= 3'h0;
         shift_r <= 8'hFF;
         rx_r <= 16'h0000;
         ackErr_r <= 1'b0;
         isAuto_r <= 1'b0;
         autoPend_r <= 1'b1;
         hold_r <= 5'h00;
         loadIdx_r <= 7'h00;
         scl_r <= 1'b1;
         sdaOe_r <= 1'b0;
         cfgWord_r <= 16'h0000;
         cfgAddr_r <= 7'h00;
         cfgValid_r <= 1'b0;
         stat_r <= eeprom_loader_pkg::STAT_RESET;
         mask_r <= eeprom_loader_pkg::STAT_RESET;
         irq_r <= 1'b0;
         rd_r <= 32'h0000_0000;
      end
      else
      begin
         state_r <= state_nxt;
         ctrl_r <= ctrl_nxt;
         q_r <= q_nxt;
         bitCnt_r <= bitCnt_nxt;
         byteIdx_r <= byteIdx_nxt;
         shift_r <= shift_nxt;
         rx_r <= rx_nxt;
         ackErr_r <= ackErr_nxt;
         isAuto_r <= isAuto_nxt;
         autoPend_r <= autoPend_nxt;
         hold_r <= hold_nxt;
         loadIdx_r <= loadIdx_nxt;
         scl_r <= scl_nxt;
         sdaOe_r <= sdaOe_nxt;
         cfgWord_r <= cfgWord_nxt;
         cfgAddr_r <= cfgAddr_nxt;
         cfgValid_r <= cfgValid_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign regRdData = rd_r;
   assign sclOut = scl_r;
   assign sdaOut = 1'b0;
   assign sdaOe = sdaOe_r;
   assign cfgWord = cfgWord_r;
   assign cfgAddr = cfgAddr_r;
   assign cfgValid = cfgValid_r;
   assign irq = irq_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_quarter3;
      !tick [*3] ##1 tick;
   endsequence

   property p_launch;
      state_r == eeprom_loader_pkg::ST_IDLE && ctrl_r.start && !autoPend_r
         |=> state_r == eeprom_loader_pkg::ST_START && !isAuto_r;
   endproperty
   a_launch: assert property (p_launch) else $error("software start did not launch");

   property p_start_clear;
      state_r == eeprom_loader_pkg::ST_FINISH && !isAuto_r
         |=> !ctrl_r.start && stat_r[eeprom_loader_pkg::STAT_OP_DONE];
   endproperty
   a_start_clear: assert property (p_start_clear) else $error("start bit not cleared");

   property p_err;
      state_r == eeprom_loader_pkg::ST_FINISH |=> ctrl_r.err == $past(ackErr_r);
   endproperty
   a_err: assert property (p_err) else $error("error flag wrong after cycle");

   property p_done;
      $rose(ctrl_r.done) |-> $past(state_r) == eeprom_loader_pkg::ST_FINISH && $past(isAuto_r)
         && !$past(ackErr_r);
   endproperty
   a_done: assert property (p_done) else $error("complete flag set without autoload");

   property p_rate;
      tick && state_r == eeprom_loader_pkg::ST_BYTE && ctrl_r.rate == 2'h3 && ctrl_r.fast
         |=> s_quarter3;
   endproperty
   a_rate: assert property (p_rate) else $error("fast top rate quarter not 4 cycles");

   property p_autodis;
      state_r == eeprom_loader_pkg::ST_IDLE && autoPend_r && ctrl_r.autoDis |=> !ctrl_r.inProg;
   endproperty
   a_autodis: assert property (p_autodis) else $error("autoload ran while disabled");

   property p_inprog;
      $fell(ctrl_r.inProg) |-> $past(state_r) == eeprom_loader_pkg::ST_FINISH && $past(isAuto_r);
   endproperty
   a_inprog: assert property (p_inprog) else $error("in-progress dropped early");

   property p_addr;
      state_r == eeprom_loader_pkg::ST_BYTE && byteIdx_r == 3'h1 && bitCnt_r == 4'h0
         |-> shift_r == {1'b0, opAddr};
   endproperty
   a_addr: assert property (p_addr) else $error("word address byte wrong");

   property p_readback;
      state_r == eeprom_loader_pkg::ST_FINISH && !isAuto_r && !ctrl_r.cmd && !ackErr_r
         |=> ctrl_r.data == $past(rx_r) && stat_r[eeprom_loader_pkg::STAT_OP_DONE];
   endproperty
   a_readback: assert property (p_readback) else $error("read word not returned");

endmodule

//--- tb/eeprom_model.sv
// Partner model: two-wire EEPROM of 128 words, word k preset to 16'h5A00 + k.
// Assumes the bench resolves the data line with a pull-up and shares the core clock.
`timescale 1ns/1ps
module eeprom_model (
   input wire logic clk,   // Core clock, used only to sample the bus
   input wire logic scl,   // Serial clock
   input wire logic sda,   // Resolved data line
   input wire logic nack,  // Withhold every acknowledge
   output logic pullLow    // High while pulling the data line low
);
   logic [15:0] mem [128];
   logic [7:0] sh;
   logic [7:0] tx;
   logic [6:0] ptr;
   logic [3:0] bitN;
   logic [2:0] byteN;
   logic pS;
   logic pD;
   logic send;
   // ------------------------------------------------------------
   // Slave framing
   // ------------------------------------------------------------
   initial
   begin
      for (int k = 0; k < 128; k++)
         mem[k] = 16'h5A00 + 16'(k);
      pullLow = 1'b0;
      send = 1'b0;
   end
   // Drive only while the clock is low, so no false start or stop is made
   always @(posedge clk)
   begin
      pS <= scl;
      pD <= sda;
      if (scl && pS && pD && !sda)
      begin
         bitN <= 4'h0;
         byteN <= 3'h0;
         send <= 1'b0;
      end
      else if (scl && !pS)
      begin
         if (bitN < 4'h8)
         begin
            sh <= {sh[6:0], sda};
            bitN <= bitN + 4'h1;
         end
         else
         begin
            bitN <= 4'h0;
            byteN <= byteN + 3'h1;
            if (send)
            begin
               tx <= mem[ptr][7:0];
               send <= (byteN == 3'h1);
            end
            else if (byteN == 3'h0 && sh[0])
            begin
               send <= 1'b1;
               tx <= mem[ptr][15:8];
            end
            else if (byteN == 3'h1)
               ptr <= sh[6:0];
            else if (byteN == 3'h2)
               tx <= sh;
            else if (byteN == 3'h3)
               mem[ptr] <= {tx, sh};
         end
      end
      else if (!scl && pS)
         pullLow <= send ? (bitN < 4'h8 && !tx[3'h7 - bitN[2:0]]) : (bitN == 4'h8 && !nack);
   end
endmodule

//--- tb/eeprom_autoload_access_bench.sv
// Bench: register tasks, autoload, word cycles, missing acknowledges, clock rates.
// Assumes the partner model presets word k to 16'h5A00 + k.
`timescale 1ns/1ps
module eeprom_autoload_access_bench;
   logic clk, reset, regWr, regRd, sdaIn, nack, pullLow, sclOut, sdaOut, sdaOe, cfgValid, irq;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, d;
   logic [15:0] cfgWord;
   logic [6:0] cfgAddr;
   int failures, comparisons, loads;
   realtime t0;
   eeprom_loader_pkg::ctrl_t c;
   // Open-drain line with pull-up
   assign sdaIn = !(sdaOe || pullLow);
   eeprom_autoload_access u_eeprom_autoload_access (.clk(clk), .reset(reset),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .sclOut(sclOut), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .cfgWord(cfgWord), .cfgAddr(cfgAddr), .cfgValid(cfgValid), .irq(irq));
   eeprom_model u_eeprom_model (.clk(clk), .scl(sclOut), .sda(sdaIn), .nack(nack),
      .pullLow(pullLow));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   // Polls the control word; the bound keeps a stuck flag from hanging
   task automatic waitCtrl(input int b, input logic v);
      int n;
      n = 0;
      rd(8'h70);
      while (d[b] !== v && n < 20000)
      begin
         rd(8'h70);
         n++;
      end
      chk("pollBit", 32'(v), 32'(d[b]));
   endtask
   // One software cycle; the serial clock period is measured on the way
   task automatic cyc(input logic cm, input logic [1:0] r, input logic f, input logic [6:0] a,
      input logic [15:0] v);
      c = '0;
      c.start = 1'b1;
      c.cmd = cm;
      c.rate = r;
      c.fast = f;
      c.wordAddr = a;
      c.data = v;
      wr(8'h70, c);
      @(posedge sclOut);
      t0 = $realtime;
      @(posedge sclOut);
      chk("sclPeriod", 32'((r == 2'h3 ? 128 : 4096 >> r) >> (f ? 3 : 0)),
         32'(int'(($realtime - t0) / 50.0)));
      waitCtrl(0, 1'b0);
      rd(8'h70);
   endtask
   task automatic final_report();
      $display("Comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Each loaded word must match what the model holds at that address
   always @(posedge clk)
      if (cfgValid === 1'b1)
      begin
         loads++;
         chk("cfgWord", 32'h5A00 + 32'(cfgAddr), 32'(cfgWord));
      end
   initial
   begin
      reset = 1'b1;
      {regWr, regRd, nack, regAddr, regWrData} = '0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(8'h70);
      chk("ctrlReset", 32'h0000_0080, d);
      chk("sdaOut", 32'h0, 32'(sdaOut));
      rd(8'h74);
      chk("unmapped", 32'h0, d);
      wr(8'h70, 32'h0000_00B0); // Fastest rate before autoload begins
      waitCtrl(8, 1'b1);
      chk("doneEarly", 32'h0, 32'(d[3]));
      waitCtrl(8, 1'b0);
      chk("autoDone", 32'h1, 32'(d[3]));
      chk("loads", 32'h8, 32'(loads));
      chk("cfgAddrLast", 32'h7, 32'(cfgAddr));
      rd(8'hA0);
      chk("statAuto", 32'h4, d);
      wr(8'hA4, 32'h4);
      repeat (2) @(posedge clk);
      #1 chk("irqSet", 32'h1, 32'(irq));
      wr(8'hA0, 32'h4);
      repeat (2) @(posedge clk);
      #1 chk("irqClr", 32'h0, 32'(irq));
      $display("Autoload test finished");
      cyc(1'b1, 2'h3, 1'b1, 7'h05, 16'h1234);
      chk("errWrite", 32'h0, 32'(d[2]));
      chk("stored", 32'h1234, 32'(u_eeprom_model.mem[5]));
      cyc(1'b0, 2'h3, 1'b1, 7'h06, 16'h0);
      chk("readWord", 32'h5A06, 32'(d[31:16]));
      cyc(1'b0, 2'h3, 1'b1, 7'h05, 16'h0);
      chk("readBack", 32'h1234, 32'(d[31:16]));
      $display("Word cycle test finished");
      nack = 1'b1;
      for (int r = 0; r < 4; r++)
      begin
         cyc(1'b0, 2'(r), 1'b1, 7'h01, 16'h0);
         chk("errSet", 32'h1, 32'(d[2]));
      end
      cyc(1'b0, 2'h3, 1'b0, 7'h01, 16'h0);
      rd(8'hA0);
      chk("statErr", 32'h3, d);
      nack = 1'b0;
      cyc(1'b0, 2'h3, 1'b1, 7'h01, 16'h0);
      chk("errClear", 32'h0, 32'(d[2]));
      $display("Error and rate test finished");
      // Second reset: autoload disabled before the hold time runs out
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      loads = 0;
      wr(8'h70, 32'h0000_00C0);
      repeat (400) @(posedge clk);
      rd(8'h70);
      chk("autoOff", 32'h0000_00C0, d);
      chk("noLoads", 32'h0, 32'(loads));
      $display("Autoload disable test finished");
      final_report();
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule
